// ==== clk_src_switch.sv ====
// Glitch-free choice between main and subclock enables for the CPU.
// Assumes both ticks are one-cycle pulses on the single system clock.
`timescale 1ns/1ps
module clk_src_switch (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic req_sub,
   input  wire logic main_tick,
   input  wire logic sub_tick,
   output logic      cpu_en,
   output logic      on_sub,
   output logic      restart_main
);

   cpu_clock_pkg::src_state_type state_ff;
   cpu_clock_pkg::src_state_type nxt_state;
   logic                         en_ff;
   logic                         nxt_en;
   logic                         sub_ff;
   logic                         nxt_sub;

   // Old source keeps driving until a subclock edge hands over
   always_comb begin
      nxt_state    = state_ff;
      nxt_en       = 1'b0;
      restart_main = 1'b0;
      unique case (state_ff)
         cpu_clock_pkg::SRC_MAIN: begin
            nxt_en = main_tick;
            if (req_sub) begin
               nxt_state = cpu_clock_pkg::SRC_TO_SUB;
            end
         end
         cpu_clock_pkg::SRC_TO_SUB: begin
            if (sub_tick) begin
               nxt_en    = 1'b1;
               nxt_state = cpu_clock_pkg::SRC_SUB;
            end else begin
               nxt_en = main_tick;
               if (!req_sub) begin
                  nxt_state = cpu_clock_pkg::SRC_MAIN;
               end
            end
         end
         cpu_clock_pkg::SRC_SUB: begin
            nxt_en = sub_tick;
            if (!req_sub) begin
               nxt_state = cpu_clock_pkg::SRC_TO_MAIN;
            end
         end
         cpu_clock_pkg::SRC_TO_MAIN: begin
            nxt_en = sub_tick;
            // back to main within one subclock period
            if (sub_tick) begin
               restart_main = 1'b1;
               nxt_state    = cpu_clock_pkg::SRC_MAIN;
            end else if (req_sub) begin
               nxt_state = cpu_clock_pkg::SRC_SUB;
            end
         end
      endcase
      // status follows the source really in use
      nxt_sub = (nxt_state == cpu_clock_pkg::SRC_SUB) ||
                (nxt_state == cpu_clock_pkg::SRC_TO_MAIN);
   end

   // Register stage
   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff <= cpu_clock_pkg::SRC_MAIN;
         en_ff    <= 1'b0;
         sub_ff   <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         en_ff    <= nxt_en;
         sub_ff   <= nxt_sub;
      end
   end

   assign cpu_en = en_ff;
   assign on_sub = sub_ff;

endmodule

// ==== cpu_clock_cfg.svh ====
// Constants of the processor clock select block: offsets, fields, resets.
// Assumes inclusion by bare name from every file that needs them.
`ifndef CPU_CLOCK_CFG_SVH
`define CPU_CLOCK_CFG_SVH

// Byte addresses on the Wishbone bus, register in byte lane 0
`define PCC_ADDR        32'hffff_f828
`define PROT_ADDR       32'hffff_f830

// Reset values
`define PCC_RESET       8'h40
`define PROT_RESET      8'h00

// Key that opens one protected write
`define PROT_KEY        8'ha5

// Bit positions of the clock control register
`define SUB_FB_BIT      7
`define MAIN_STOP_BIT   6
`define MAIN_FB_BIT     5
`define STATUS_BIT      4
`define SUBSEL_BIT      3
`define DIV_HI_BIT      2

// Bit positions of the protection register
`define PROT_ERR_BIT    0
`define PROT_ARM_BIT    1

// Highest legal divider code (divide by 32)
`define DIV_CODE_MAX    3'h5

// System clock rate, for reference by counts
`define CLK_FREQ_HZ     40000000

`endif

// ==== cpu_clock_pkg.sv ====
// Types shared by the processor clock select block.
// Assumes nothing of its surroundings.
package cpu_clock_pkg;

   // Phases of the CPU clock source switch
   typedef enum logic [1:0] {
      SRC_MAIN,
      SRC_TO_SUB,
      SRC_SUB,
      SRC_TO_MAIN
   } src_state_type;

   typedef logic [7:0] byte_reg_type;
   typedef logic [2:0] div_code_type;

endpackage

// ==== cpu_clock_select_switch.sv ====
// Processor clock control: protected control register on Wishbone,
// main clock divider, subclock hand-over and oscillator controls.
// Assumes a classic Wishbone master on CLK and subclock ticks as pulses.
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/1ps
`include "cpu_clock_cfg.svh"
module cpu_clock_select_switch (
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic        CYC_I,
   input  wire logic        STB_I,
   input  wire logic        WE_I,
   input  wire logic [31:0] ADR_I,
   input  wire logic [3:0]  SEL_I,
   input  wire logic [31:0] DAT_I,
   output logic      [31:0] DAT_O,
   output logic             ACK_O,
   input  wire logic        XT_TICK,
   input  wire logic        RL_TICK,
   input  wire logic        SUBCLOCK_SOURCE_OPTION_OPTION,
   output logic             CPU_CLK_EN,
   output logic             CPU_ON_SUB,
   output logic             MAIN_OSC_EN,
   output logic             MAIN_FB_CONNECT,
   output logic             SUB_FB_CONNECT
);

   // Bus handshake and read data
   logic                        ack_ff;
   logic                        nxt_ack;
   logic [31:0]                 dat_ff;
   logic [31:0]                 nxt_dat;

   // Control register (status bit is not stored) and protection
   cpu_clock_pkg::byte_reg_type ctrl_ff;
   cpu_clock_pkg::byte_reg_type nxt_ctrl;
   logic                        armed_ff;
   logic                        nxt_armed;
   logic                        err_ff;
   logic                        nxt_err;

   // Strap capture after reset release
   logic                        rst_d_ff;
   logic                        nxt_rst_d;
   logic                        opt_ff;
   logic                        nxt_opt;

   // Internal connections
   logic                        req;
   logic                        hit_ctrl;
   logic                        hit_prot;
   logic                        lane0_wr;
   logic                        ctrl_wr_ok;
   logic                        sub_tick;
   logic                        main_tick;
   logic                        restart_main;
   logic                        on_sub;
   logic                        cpu_en;
   logic                        osc_run;
   cpu_clock_pkg::byte_reg_type ctrl_view;

   // True for divider codes 6 and 7 written with select bit 3 clear
   function automatic logic code_prohibited(input logic [3:0] c);
      return !c[3] && (c[2:0] > `DIV_CODE_MAX);
   endfunction

   // Address decode; a new request only when no ack is pending
   assign req      = CYC_I && STB_I && !ack_ff;
   assign hit_ctrl = (ADR_I == `PCC_ADDR);
   assign hit_prot = (ADR_I == `PROT_ADDR);
   assign lane0_wr = req && WE_I && SEL_I[0];

   // a control write needs the key written just before it
   assign ctrl_wr_ok = lane0_wr && hit_ctrl && armed_ff &&
                       !code_prohibited(DAT_I[3:0]);

   // Register as software sees it, live status in bit 4
   always_comb begin
      ctrl_view = ctrl_ff;
      // read-only status of the real CPU source
      ctrl_view[`STATUS_BIT] = on_sub;
   end

   // Wishbone slave: one-cycle ack, unmapped reads return zero
   always_comb begin
      nxt_ack = req;
      nxt_dat = 32'h0000_0000;
      if (req && !WE_I) begin
         if (hit_ctrl) begin
            nxt_dat = {24'h00_0000, ctrl_view};
         end else if (hit_prot) begin
            nxt_dat[`PROT_ERR_BIT] = err_ff;
            nxt_dat[`PROT_ARM_BIT] = armed_ff;
         end
      end
   end

   // Protection: key arms one write; any other lane 0 write disarms it
   always_comb begin
      nxt_armed = armed_ff;
      nxt_err   = err_ff;
      if (lane0_wr) begin
         nxt_armed = hit_prot && (DAT_I[7:0] == `PROT_KEY);
         if (hit_prot) begin
            nxt_err = 1'b0;
         end
         // A refused control write sets the error; set wins over clear
         if (hit_ctrl && !ctrl_wr_ok) begin
            nxt_err = 1'b1;
         end
      end
   end

   // Control register update, status bit never written
   always_comb begin
      nxt_ctrl = ctrl_ff;
      if (ctrl_wr_ok) begin
         // divider codes 6 and 7 were refused above unless bit 3 was set
         nxt_ctrl = DAT_I[7:0];
         nxt_ctrl[`STATUS_BIT] = 1'b0;
      end
   end

   // strap is sampled in the first cycle after reset release
   always_comb begin
      nxt_rst_d = RST;
      nxt_opt   = opt_ff;
      if (rst_d_ff && !RST) begin
         nxt_opt = SUBCLOCK_SOURCE_OPTION_OPTION;
      end
   end

   // Register stage of bus, control and strap state
   always_ff @(posedge CLK) begin
      if (RST) begin
         ack_ff   <= 1'b0;
         dat_ff   <= 32'h0000_0000;
         // reset value of the control register
         ctrl_ff  <= `PCC_RESET;
         armed_ff <= 1'b0;
         err_ff   <= 1'b0;
         rst_d_ff <= 1'b1;
         opt_ff   <= 1'b0;
      end else begin
         ack_ff   <= nxt_ack;
         dat_ff   <= nxt_dat;
         ctrl_ff  <= nxt_ctrl;
         armed_ff <= nxt_armed;
         err_ff   <= nxt_err;
         rst_d_ff <= nxt_rst_d;
         opt_ff   <= nxt_opt;
      end
   end

   // subclock edge from crystal or slow internal oscillator
   assign sub_tick = opt_ff ? RL_TICK : XT_TICK;

   // oscillator keeps running until the CPU has left it
   assign osc_run = !(ctrl_ff[`MAIN_STOP_BIT] && on_sub);

   // main clock divided by 2 to the code, codes 6 and 7 by 32 as code 5
   main_clk_divider #(
      .CW       (5)
   ) u_div (
      .clk      (CLK),
      .rst      (RST),
      .run      (osc_run),
      .restart  (restart_main),
      .div_code (ctrl_ff[`DIV_HI_BIT:0]),
      .tick     (main_tick)
   );

   // hand-over between sources only on a subclock edge
   clk_src_switch u_sw (
      .clk          (CLK),
      .rst          (RST),
      .req_sub      (ctrl_ff[`SUBSEL_BIT]),
      .main_tick    (main_tick),
      .sub_tick     (sub_tick),
      .cpu_en       (cpu_en),
      .on_sub       (on_sub),
      .restart_main (restart_main)
   );

   // Outputs; feedback resistors are connected while their bit is clear
   assign DAT_O           = dat_ff;
   assign ACK_O           = ack_ff;
   assign CPU_CLK_EN      = cpu_en;
   assign CPU_ON_SUB      = on_sub;
   assign MAIN_OSC_EN     = osc_run;
   assign MAIN_FB_CONNECT = !ctrl_ff[`MAIN_FB_BIT];
   assign SUB_FB_CONNECT  = !ctrl_ff[`SUB_FB_BIT];

endmodule

// ==== cpu_clock_sva.sv ====
// Checker of the processor clock select block, bound to its top module.
// Assumes one clock CLK and a synchronous active-high RST.
`timescale 1ns/1ps
module cpu_clock_sva (
   input wire logic        CLK,
   input wire logic        RST,
   input wire logic        CYC_I,
   input wire logic        STB_I,
   input wire logic [31:0] DAT_O,
   input wire logic        ACK_O,
   input wire logic        XT_TICK,
   input wire logic        RL_TICK,
   input wire logic        CPU_CLK_EN,
   input wire logic        CPU_ON_SUB,
   input wire logic        MAIN_OSC_EN,
   input wire logic        MAIN_FB_CONNECT,
   input wire logic        SUB_FB_CONNECT
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   // New request, then its single ack cycle
   sequence req_s;
      CYC_I && STB_I && !ACK_O;
   endsequence
   sequence ans_s;
      ACK_O ##1 !ACK_O;
   endsequence
   // A subclock tick one edge back; status may only move on it
   sequence tick_s;
      $past(XT_TICK) || $past(RL_TICK);
   endsequence

   bus_answer_a: assert property (req_s |=> ans_s)
      else $error("bus request not answered by one ack");
   read_idle_a: assert property (!ACK_O |-> DAT_O == 32'h0000_0000)
      else $error("read data outside ack");
   reset_value_a: assert property (disable iff (1'b0)
      RST |=> !ACK_O && !CPU_ON_SUB && MAIN_OSC_EN && MAIN_FB_CONNECT
      && SUB_FB_CONNECT && !CPU_CLK_EN) else $error("reset state wrong");
   osc_hold_a: assert property (!MAIN_OSC_EN |-> CPU_ON_SUB)
      else $error("main oscillator off while on main clock");
   osc_fall_a: assert property ($fell(MAIN_OSC_EN)
      |-> $rose(CPU_ON_SUB) || ACK_O) else $error("oscillator stop odd");
   osc_rise_a: assert property ($rose(MAIN_OSC_EN)
      |-> ACK_O) else $error("oscillator start without write");
   sub_edge_a: assert property ($rose(CPU_ON_SUB)
      |-> tick_s ##0 CPU_CLK_EN) else $error("switch to sub off tick");
   sub_pace_a: assert property (CPU_ON_SUB && $past(CPU_ON_SUB)
      && CPU_CLK_EN |-> tick_s) else $error("cpu edge without sub tick");
   // Last subclock edge still clocks the CPU while the divider restarts
   main_back_a: assert property ($fell(CPU_ON_SUB)
      |-> tick_s ##0 CPU_CLK_EN) else $error("return to main odd");
   main_fb_a: assert property ($changed(MAIN_FB_CONNECT) |-> ACK_O)
      else $error("main feedback moved without write");
   sub_fb_a: assert property ($changed(SUB_FB_CONNECT) |-> ACK_O)
      else $error("sub feedback moved without write");
endmodule

bind cpu_clock_select_switch cpu_clock_sva u_sva (
   .CLK(CLK), .RST(RST), .CYC_I(CYC_I), .STB_I(STB_I), .DAT_O(DAT_O),
   .ACK_O(ACK_O), .XT_TICK(XT_TICK), .RL_TICK(RL_TICK),
   .CPU_CLK_EN(CPU_CLK_EN), .CPU_ON_SUB(CPU_ON_SUB),
   .MAIN_OSC_EN(MAIN_OSC_EN), .MAIN_FB_CONNECT(MAIN_FB_CONNECT),
   .SUB_FB_CONNECT(SUB_FB_CONNECT)
);

// ==== main_clk_divider.sv ====
// Divider of the main clock into a one-cycle enable, ratio 1 to 32.
// Assumes CLK is the main system clock and run low when it is stopped.
`timescale 1ns/1ps
module main_clk_divider #(
   parameter int CW = 5
) (
   input  wire logic                       clk,
   input  wire logic                       rst,
   input  wire logic                       run,
   input  wire logic                       restart,
   input  wire cpu_clock_pkg::div_code_type div_code,
   output logic                            tick
);

   logic [CW-1:0]              cnt_ff;
   logic [CW-1:0]              nxt_cnt;
   cpu_clock_pkg::div_code_type code_ff;
   cpu_clock_pkg::div_code_type nxt_code;
   logic                       tick_ff;
   logic                       nxt_tick;

   // Last count of a period for a divider code
   function automatic logic [CW-1:0] last_cnt(input logic [2:0] c);
      logic [CW:0] w;
      w = ({{CW{1'b0}}, 1'b1} << c) - {{CW{1'b0}}, 1'b1};
      return w[CW-1:0];
   endfunction

   // A new ratio is only taken at a period end or on restart, so no runt enable
   always_comb begin
      nxt_cnt  = cnt_ff;
      nxt_code = code_ff;
      nxt_tick = 1'b0;
      if (restart) begin
         nxt_cnt  = '0;
         nxt_code = div_code;
      end else if (run) begin
         if (cnt_ff == last_cnt(code_ff)) begin
            nxt_cnt  = '0;
            nxt_code = div_code;
            nxt_tick = 1'b1;
         end else begin
            nxt_cnt = cnt_ff + {{(CW-1){1'b0}}, 1'b1};
         end
      end
   end

   // Register stage
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_ff  <= '0;
         code_ff <= 3'h0;
         tick_ff <= 1'b0;
      end else begin
         cnt_ff  <= nxt_cnt;
         code_ff <= nxt_code;
         tick_ff <= nxt_tick;
      end
   end

   assign tick = tick_ff;

endmodule

// ==== testbench.sv ====
// Self-checking bench of the processor clock select block.
// Assumes the checker is bound to the design from its own file.
`timescale 1ns/1ps
`include "cpu_clock_cfg.svh"
module testbench;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [3:0]  sel = 4'h1;
   logic [31:0] adr = 32'h0000_0000;
   logic [31:0] wdat = 32'h0000_0000;
   logic        xt = 1'b0;
   logic        rl = 1'b0;
   logic        opt = 1'b0;
   logic [31:0] dat_o;
   logic        ack;
   logic        cpu_en;
   logic        on_sub;
   logic        osc_en;
   logic        mfb;
   logic        sfb;
   logic [31:0] rd;
   int          n;
   int          error_cnt = 0;
   int          total_checks = 0;
   // Rows: key mode (0 none, 1 key, 2 key then other write), data, readback
   logic [19:0] rows [7] = '{20'h1_2525, 20'h0_0025, 20'h1_b0a0,
      20'h1_06a0, 20'h2_c3a0, 20'h1_c3c3, 20'h1_47c3};

   cpu_clock_select_switch u_dut (
      .CLK(clk), .RST(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
      .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(dat_o), .ACK_O(ack),
      .XT_TICK(xt), .RL_TICK(rl), .SUBCLOCK_SOURCE_OPTION_OPTION(opt),
      .CPU_CLK_EN(cpu_en), .CPU_ON_SUB(on_sub), .MAIN_OSC_EN(osc_en),
      .MAIN_FB_CONNECT(mfb), .SUB_FB_CONNECT(sfb)
   );

   // Free-running 40 MHz clock
   always #12.5 clk = ~clk;

   task wrap_up;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // A wait that ran out of its bound ends the run
   task fail_wait;
      error_cnt++;
      wrap_up;
   endtask

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Classic cycle: hold until ack, take data there, then one idle cycle
   task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) fail_wait;
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask

   task pw(input logic [7:0] d);
      bus(1'b1, `PROT_ADDR, {24'h00_0000, `PROT_KEY});
      bus(1'b1, `PCC_ADDR, {24'h00_0000, d});
   endtask

   // One tick of the chosen subclock source; status moves on the next edge
   task pulse(input logic b);
      if (b) rl <= 1'b1;
      else xt <= 1'b1;
      @(posedge clk);
      rl <= 1'b0;
      xt <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   // Cycles from one CPU clock edge to the next, bounded
   task gap;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (cpu_en !== 1'b1 && n < 64);
      if (cpu_en !== 1'b1) fail_wait;
   endtask

   task do_reset(input logic b);
      rst <= 1'b1;
      opt <= b;
      repeat (16) @(posedge clk);
      chk({28'h0, ack, on_sub, osc_en, mfb & sfb}, 32'h0000_0003);
      rst <= 1'b0;
      @(posedge clk);
      bus(1'b0, `PCC_ADDR, 32'h0000_0000);
      chk(rd, {24'h00_0000, `PCC_RESET});
   endtask

   // Round trip main to subclock and back; b picks the strap
   task sw_run(input logic b);
      // no PLL, fast oscillator or clock output here
      pw(8'h43);
      chk({31'h0, osc_en}, 32'h0000_0001);
      // select bit alone, divide by 8 is fast enough
      pw(8'h4b);
      pulse(!b);
      chk({31'h0, on_sub}, 32'h0000_0000);
      pulse(b);
      chk({30'h0, on_sub, osc_en}, 32'h0000_0002);
      bus(1'b0, `PCC_ADDR, 32'h0000_0000);
      chk(rd, 32'h0000_005b);
      pw(8'h0b);
      chk({31'h0, osc_en}, 32'h0000_0001);
      // status seen before the next selection
      pw(8'h03);
      pulse(b);
      chk({31'h0, on_sub}, 32'h0000_0000);
      gap;
      gap;
      chk(32'(n), 32'h0000_0008);
   endtask

   initial begin
      do_reset(1'b0);
      // Register rows: protected, unprotected, disarmed and refused writes
      foreach (rows[i]) begin
         if (rows[i][19:16] == 1) pw(rows[i][15:8]);
         else if (rows[i][19:16] == 0)
            bus(1'b1, `PCC_ADDR, {24'h00_0000, rows[i][15:8]});
         if (rows[i][19:16] == 2) begin
            bus(1'b1, `PROT_ADDR, {24'h00_0000, `PROT_KEY});
            bus(1'b1, 32'h0000_0100, 32'h0000_0000);
            bus(1'b1, `PCC_ADDR, {24'h00_0000, rows[i][15:8]});
         end
         bus(1'b0, `PCC_ADDR, 32'h0000_0000);
         chk(rd, {24'h00_0000, rows[i][7:0]});
         chk({29'h0, mfb, sfb, osc_en},
            {29'h0, !rows[i][5], !rows[i][7], 1'b1});
         bus(1'b0, `PROT_ADDR, 32'h0000_0000);
         chk(rd, {31'h0, rows[i][19:16] != 1
            || rows[i][11:9] == 3'b011});
      end
      bus(1'b0, 32'h0000_0100, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      // writes off lane 0 neither arm nor land
      sel <= 4'h2;
      pw(8'h00);
      sel <= 4'h1;
      bus(1'b0, `PCC_ADDR, 32'h0000_0000);
      chk(rd, 32'h0000_00c3);
      bus(1'b0, `PROT_ADDR, 32'h0000_0000);
      chk(rd, 32'h0000_0001);
      // a read between key and write keeps the key armed
      bus(1'b1, `PROT_ADDR, {24'h00_0000, `PROT_KEY});
      bus(1'b0, `PROT_ADDR, 32'h0000_0000);
      chk(rd, 32'h0000_0002);
      bus(1'b1, `PCC_ADDR, 32'h0000_0005);
      bus(1'b0, `PCC_ADDR, 32'h0000_0000);
      chk(rd, 32'h0000_0005);
      // Every legal divider code 0 to 5; old period ends before measuring
      for (int c = 0; c < 6; c++) begin
         pw(c[7:0]);
         repeat (40) @(posedge clk);
         gap;
         gap;
         chk(32'(n), 32'(1 << c));
      end
      sw_run(1'b0);
      do_reset(1'b1);
      sw_run(1'b1);
      wrap_up;
   end
endmodule
